/* File: src/timer_ctl_pkg.sv */
package timer_ctl_pkg;
  // Register map, word offsets on the bus
  localparam logic [1:0] ADDR_CTRL_EVEN = 2'h0;
  localparam logic [1:0] ADDR_CTRL_ODD = 2'h1;
  localparam logic [1:0] ADDR_COUNT_EVEN = 2'h2;
  localparam logic [1:0] ADDR_COUNT_ODD = 2'h3;
  // Control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PAIR = 3;
  localparam int BIT_CS = 1;
  // Implemented bits of the control word
  localparam logic [15:0] CTRL_MASK = 16'ha07a;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ODD_CTRL_MASK = 16'ha072;
  // Prescale codes and terminal counts
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] PS_TOP1 = 8'h00;
  localparam logic [7:0] PS_TOP8 = 8'h07;
  localparam logic [7:0] PS_TOP64 = 8'h3f;
  localparam logic [7:0] PS_TOP256 = 8'hff;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

/* File: src/timer_tick_gen.sv */
`timescale 1ns/1ps
// One timer's input qualification and prescaler
module timer_tick_gen
  import timer_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic idle_halt,
  input wire logic idle_mode,
  input wire logic gate_accumulate_en,
  input wire logic clock_source_select,
  input wire logic [1:0] prescale_select,
  // Clock sources
  input wire logic ext_clk,
  input wire logic gate_in,
  // Prescaled count pulse
  output logic tick
);
  logic ext_d_reg;
  logic [7:0] ps_reg;
  logic [7:0] ps_top;
  logic src_pulse;
  logic active;

  // Previous external level for edge detect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_d_reg <= 1'b0;
    end else begin
      ext_d_reg <= ext_clk;
    end
  end

  // Prescale terminal count
  always_comb begin
    case (prescale_select)
      PS_DIV1: ps_top = PS_TOP1;
      PS_DIV8: ps_top = PS_TOP8;
      PS_DIV64: ps_top = PS_TOP64;
      PS_DIV256: ps_top = PS_TOP256;
      default: ps_top = PS_TOP1;
    endcase
  end

  // Source choice and gating
  always_comb begin
    active = run && !(idle_halt && idle_mode);
    if (clock_source_select) begin
      src_pulse = ext_clk && !ext_d_reg;
    end else if (gate_accumulate_en) begin
      src_pulse = gate_in;
    end else begin
      src_pulse = 1'b1;
    end
  end

  // Prescaler counter, cleared while stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!active) begin
        ps_reg <= 8'h00;
      end else if (src_pulse) begin
        if (ps_reg >= ps_top) begin
          ps_reg <= 8'h00;
          tick <= 1'b1;
        end else begin
          ps_reg <= ps_reg + 8'h01;
        end
      end
    end
  end
endmodule

/* File: src/paired_timer_control.sv */
`timescale 1ns/1ps
// Functional notes
// - With pairing set, run bit starts and stops the 32-bit pair.
// - With pairing clear, run bit controls only this 16-bit timer.
// - Idle-halt bit stops counting in idle; clear keeps it running.
// - External clock selected means gating bit is ignored.
// - Internal clock: gating bit enables gated time accumulation.
// - Prescale code 11 divides the timer input by 256.
// - Unimplemented control bits ignore writes and read as zero.
// - In pair mode odd count holds high word, even holds low word.
// - Pair interrupt comes through the odd timer's flag.
module paired_timer_control
  import timer_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device state and timer inputs
  input wire logic idle_mode,
  input wire logic ext_clk_even,
  input wire logic ext_clk_odd,
  input wire logic gate_even,
  input wire logic gate_odd,
  // Count rollover events
  output logic match_even,
  output logic match_odd
);
  logic [15:0] ctrl_even_reg;
  logic [15:0] ctrl_odd_reg;
  logic [15:0] count_even_reg;
  logic [15:0] count_odd_reg;
  logic ack_reg;
  logic tick_even;
  logic tick_odd;
  logic pair_wide_mode;
  logic odd_run;
  logic wr_en;
  logic [15:0] wmask;
  logic [15:0] wdata;

  assign pair_wide_mode = ctrl_even_reg[BIT_PAIR];
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wdata = writedata[15:0];
  // Writes land at the edge where waitrequest is seen low
  assign wr_en = write && ack_reg;

  // One wait state per access
  assign waitrequest = (read || write) && !ack_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  // Even control register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_even_reg <= CTRL_RESET;
    end else if (wr_en && address == ADDR_CTRL_EVEN) begin
      ctrl_even_reg <= (ctrl_even_reg & ~(wmask & CTRL_MASK))
        | (wdata & wmask & CTRL_MASK);
    end
  end

  // Odd control register, no pairing bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_odd_reg <= CTRL_RESET;
    end else if (wr_en && address == ADDR_CTRL_ODD) begin
      ctrl_odd_reg <= (ctrl_odd_reg & ~(wmask & ODD_CTRL_MASK))
        | (wdata & wmask & ODD_CTRL_MASK);
    end
  end

  // Even timer prescaler and gating
  timer_tick_gen u_even (
    .clk(clk),
    .reset_n(reset_n),
    .run(ctrl_even_reg[BIT_RUN]),
    .idle_halt(ctrl_even_reg[BIT_IDLE]),
    .idle_mode(idle_mode),
    .gate_accumulate_en(ctrl_even_reg[BIT_GATE]),
    .clock_source_select(ctrl_even_reg[BIT_CS]),
    .prescale_select(ctrl_even_reg[BIT_PS_HI:BIT_PS_LO]),
    .ext_clk(ext_clk_even),
    .gate_in(gate_even),
    .tick(tick_even)
  );

  // Odd timer only runs on its own when unpaired
  assign odd_run = ctrl_odd_reg[BIT_RUN] && !pair_wide_mode;
  timer_tick_gen u_odd (
    .clk(clk),
    .reset_n(reset_n),
    .run(odd_run),
    .idle_halt(ctrl_odd_reg[BIT_IDLE]),
    .idle_mode(idle_mode),
    .gate_accumulate_en(ctrl_odd_reg[BIT_GATE]),
    .clock_source_select(ctrl_odd_reg[BIT_CS]),
    .prescale_select(ctrl_odd_reg[BIT_PS_HI:BIT_PS_LO]),
    .ext_clk(ext_clk_odd),
    .gate_in(gate_odd),
    .tick(tick_odd)
  );

  // Even count: low word in pair mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_even_reg <= 16'h0000;
    end else if (wr_en && address == ADDR_COUNT_EVEN) begin
      count_even_reg <= (count_even_reg & ~wmask) | (wdata & wmask);
    end else if (tick_even) begin
      count_even_reg <= count_even_reg + COUNT_ONE;
    end
  end

  // Odd count: high word in pair mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_odd_reg <= 16'h0000;
    end else if (wr_en && address == ADDR_COUNT_ODD) begin
      count_odd_reg <= (count_odd_reg & ~wmask) | (wdata & wmask);
    end else if (pair_wide_mode && tick_even
                 && count_even_reg == COUNT_MAX) begin
      count_odd_reg <= count_odd_reg + COUNT_ONE;
    end else if (!pair_wide_mode && tick_odd) begin
      count_odd_reg <= count_odd_reg + COUNT_ONE;
    end
  end

  // Rollover events; pair reports through odd flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_even <= 1'b0;
      match_odd <= 1'b0;
    end else begin
      match_even <= !pair_wide_mode && tick_even
        && count_even_reg == COUNT_MAX;
      match_odd <= pair_wide_mode
        ? (tick_even && count_even_reg == COUNT_MAX
           && count_odd_reg == COUNT_MAX)
        : (tick_odd && count_odd_reg == COUNT_MAX);
    end
  end

  // Read data registered, zeros in unused bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_reg) begin
      case (address)
        ADDR_CTRL_EVEN: readdata <= {16'h0000, ctrl_even_reg};
        ADDR_CTRL_ODD: readdata <= {16'h0000, ctrl_odd_reg};
        ADDR_COUNT_EVEN: readdata <= {16'h0000, count_even_reg};
        ADDR_COUNT_ODD: readdata <= {16'h0000, count_odd_reg};
        default: readdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: verif/timer_ctl_monitor.sv */
`timescale 1ns/1ps
module timer_ctl_monitor
  import timer_ctl_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Timer pins
  input wire logic idle_mode,
  input wire logic gate_even,
  input wire logic gate_odd,
  input wire logic match_even,
  input wire logic match_odd
);
  logic [15:0] ce_reg, co_reg;
  logic [2:0] qe_reg, qo_reg;
  logic se, so, sp;
  // Conditions under which a timer cannot raise its match
  assign sp = !ce_reg[15] || idle_mode && ce_reg[13];
  assign se = sp || ce_reg[3] || !ce_reg[1] && ce_reg[6] && !gate_even;
  assign so = ce_reg[3] ? sp || !ce_reg[1] && ce_reg[6] && !gate_even :
    !co_reg[15] || idle_mode && co_reg[13] ||
    !co_reg[1] && co_reg[6] && !gate_odd;
  // Shadow control words and stopped-cycle counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_reg <= 16'h0000;
      co_reg <= 16'h0000;
      qe_reg <= 3'h0;
      qo_reg <= 3'h0;
    end else begin
      if (write && !waitrequest && address == ADDR_CTRL_EVEN)
        ce_reg <= writedata[15:0];
      if (write && !waitrequest && address == ADDR_CTRL_ODD)
        co_reg <= writedata[15:0];
      qe_reg <= !se ? 3'h0 : qe_reg + {2'h0, qe_reg != 3'h7};
      qo_reg <= !so ? 3'h0 : qo_reg + {2'h0, qo_reg != 3'h7};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_first_a: assert property (
    $rose(read || write) |-> waitrequest) else $error("no wait cycle");
  wait_once_a: assert property ((read || write) && waitrequest |=>
    !waitrequest) else $error("wait too long");
  wait_idle_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  upper_zero_a: assert property (readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  ctrl_unimpl_a: assert property (
    read && !waitrequest && !address[1] |->
    (readdata[15:0] & ~(address[0] ? ODD_CTRL_MASK : CTRL_MASK)) == 16'h0)
    else $error("unimplemented bit reads one");
  even_stop_a: assert property (
    qe_reg == 3'h7 |-> !match_even) else $error("stopped even timer matched");
  odd_stop_a: assert property (qo_reg == 3'h7 |-> !match_odd)
    else $error("stopped odd timer matched");
  pair_even_a: assert property (
    ce_reg[3] && $past(ce_reg[3]) |-> !match_even)
    else $error("even match in pair mode");
  match_pulse_a: assert property (match_even |=> !match_even)
    else $error("match longer than a pulse");
endmodule

bind paired_timer_control timer_ctl_monitor mon (.clk(clk),
  .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .idle_mode(idle_mode), .gate_even(gate_even), .gate_odd(gate_odd),
  .match_even(match_even), .match_odd(match_odd));

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench
  import timer_ctl_pkg::*;
;
  logic clk = 0, reset_n = 0, read = 0, write = 0, idle_mode = 0;
  logic ext_clk_even = 0, gate_even = 0, ext_on = 0;
  logic match_even, match_odd, waitrequest;
  logic [1:0] address = 2'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic [15:0] q;
  int fails = 0, checks = 0, cyc = 0, seen_odd = 0, seen_even = 0;
  int dv[4] = '{1, 8, 64, 256};
  paired_timer_control uut (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .idle_mode(idle_mode),
    .ext_clk_even(ext_clk_even), .ext_clk_odd(1'b0),
    .gate_even(gate_even), .gate_odd(1'b0),
    .match_even(match_even), .match_odd(match_odd));
  always #12.5 clk = ~clk;
  // Cycle count, external clock, even and odd match watch, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ext_on && cyc[1:0] == 2'h0) ext_clk_even <= ~ext_clk_even;
    if (match_odd === 1'b1) seen_odd <= seen_odd + 1;
    if (match_even === 1'b1) seen_even <= seen_even + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      final_report;
    end
  end
  task final_report;
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus access, held until the wait is over
  task bus(input logic wr, input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read <= 0;
    write <= 0;
  endtask
  // Run the even timer from fff0 for n cycles, check ticks counted
  task meas(input logic [15:0] ctl, input int n, lo, hi);
    bus(1, ADDR_COUNT_EVEN, 16'hfff0);
    bus(1, ADDR_CTRL_EVEN, ctl);
    repeat (n) @(posedge clk);
    bus(1, ADDR_CTRL_EVEN, 16'h0);
    bus(0, ADDR_COUNT_EVEN, 16'h0);
    q = q - 16'hfff0;
    chk(16'(q >= lo && q <= hi), 16'h1);
  endtask
  initial begin
    logic [15:0] d;
    logic a;
    void'($urandom(48697));
    repeat (2) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) begin
      bus(0, 2'(i), 16'h0);
      chk(q, 16'h0);
    end
    repeat (8) begin
      d = 16'($urandom) & 16'h7fff;
      a = 1'($urandom);
      bus(1, {1'b0, a}, d);
      bus(0, {1'b0, a}, 16'h0);
      chk(q, d & (a ? ODD_CTRL_MASK : CTRL_MASK));
    end
    for (int p = 0; p < 4; p++)
      meas(16'h8000 | 16'(p << 4), 1024, 1024 / dv[p] - 1,
        1028 / dv[p] + 1);
    ext_on <= 1;
    meas(16'h8042, 80, 8, 11);
    ext_on <= 0;
    meas(16'h8002, 80, 0, 0);
    meas(16'h8040, 200, 0, 0);
    gate_even <= 1;
    meas(16'h8040, 200, 199, 205);
    idle_mode <= 1;
    meas(16'ha000, 200, 0, 0);
    meas(16'h8000, 200, 199, 205);
    idle_mode <= 0;
    // Odd timer alone, then stopped while the even one runs
    bus(1, ADDR_COUNT_ODD, 16'h0);
    bus(1, ADDR_CTRL_ODD, 16'h8000);
    repeat (50) @(posedge clk);
    bus(1, ADDR_CTRL_ODD, 16'h0);
    bus(0, ADDR_COUNT_ODD, 16'h0);
    chk(16'(q >= 50 && q <= 56), 16'h1);
    bus(1, ADDR_COUNT_ODD, 16'h0);
    meas(16'h8000, 100, 99, 105);
    bus(0, ADDR_COUNT_ODD, 16'h0);
    chk(q, 16'h0);
    chk(16'(seen_even > 0), 16'h1);
    chk(16'(seen_odd == 0), 16'h1);
    // Pair: odd word at its top so the 32-bit rollover is seen
    bus(1, ADDR_COUNT_ODD, 16'hffff);
    meas(16'h8008, 100, 99, 105);
    bus(0, ADDR_COUNT_ODD, 16'h0);
    chk(q, 16'h0);
    chk(16'(seen_odd > 0), 16'h1);
    final_report;
  end
endmodule
